//--- rbl_map.vh
// constants for the reset boot loader
`ifndef RBL_MAP_VH
`define RBL_MAP_VH
`define RBL_MODE_EXT     3'h0
`define RBL_MODE_FLASH8  3'h1
`define RBL_MODE_SPI8    3'h2
`define RBL_MODE_SPI16   3'h3
`define RBL_EXT_START    32'h02000000
`define RBL_L2_START     32'h00000000
`define RBL_SPI_READ_CMD 8'h03
`define RBL_SPI_ADDR     16'h0000
`define RBL_FL_SETUP     5'h04
`define RBL_FL_ACCESS    5'h0f
`define RBL_FL_HOLD      5'h03
`define RBL_SCK_HALF     4'h4
`define RBL_HDR_BYTES    3'h4
`define RBL_FIFO_DEPTH   8
`endif

//--- rbl_fifo.v
// byte fifo between the boot source and the l2 write port
`timescale 1ns/1ps
module rbl_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk_in,
  input  wire             rst_in,
  input  wire             clr_in,
  input  wire [WIDTH-1:0] wr_data_in,
  input  wire             wr_valid_in,
  output wire             wr_ready_out,
  output reg  [WIDTH-1:0] rd_data_out,
  output wire             rd_valid_out,
  input  wire             rd_ready_in
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW:0]      wp_q;
  reg [AW:0]      rp_q;
  wire            full_w  = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
  wire            empty_w = (wp_q == rp_q);
  wire            push_w  = wr_valid_in && !full_w;
  wire            pop_w   = rd_ready_in && !empty_w;
  wire [AW-1:0]   nxt_w   = pop_w ? rp_q[AW-1:0] + 1'b1 : rp_q[AW-1:0];
  assign wr_ready_out = !full_w;
  assign rd_valid_out = !empty_w;
  // storage write
  always @(posedge clk_in) begin
    if (push_w) begin
      mem_q[wp_q[AW-1:0]] <= wr_data_in;
    end
  end
  // pointers and registered head data
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wp_q        <= {(AW+1){1'b0}};
      rp_q        <= {(AW+1){1'b0}};
      rd_data_out <= {WIDTH{1'b0}};
    end else if (clr_in) begin
      wp_q <= {(AW+1){1'b0}};
      rp_q <= {(AW+1){1'b0}};
    end else begin
      if (push_w) begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop_w) begin
        rp_q <= rp_q + 1'b1;
      end
      // a byte pushed into the next head slot bypasses the storage read
      rd_data_out <= (push_w && (wp_q[AW-1:0] == nxt_w)) ? wr_data_in : mem_q[nxt_w];
    end
  end
endmodule // rbl_fifo

//--- rbl_boot.v
// reset boot sequencer: strap decode, flash or spi load into l2, then jump
// Overview of operation
// - strap 000 external execution, 001 eight-bit flash, 010 spi eight-bit address.
// - strap 011 spi sixteen-bit address; 100 to 111 reserved, no boot.
// - strap captured on every power-on reset and software reset.
// - external mode skips loading, starts fetch at 0x2000000 with 16-bit packing.
// - flash read on bank 0 with 4 setup, 15 access, 3 hold cycles.
// - spi boot drives select flag, sends read command at address 0x00.
// - sixteen-bit spi mode sends two address bytes 0x0000.
// - first four bytes read give the byte count to load.
// - after the load, jump to the first l2 address.
// - bypass setting makes a software reset jump straight to l2 start.
`timescale 1ns/1ps
`include "rbl_map.vh"
module rbl_boot (
  input  wire        clk_in,
  input  wire        rst_in,
  input  wire        sw_reset_in,
  input  wire        sw_bypass_in,
  input  wire [2:0]  boot_select_strap_in,
  output reg         flash_bank0_sel_out,
  output reg         flash_rd_out,
  output reg  [31:0] flash_addr_out,
  input  wire [7:0]  flash_data_in,
  output reg         spi_boot_device_select_out,
  output reg         spi_sck_out,
  output reg         spi_mosi_out,
  input  wire        spi_miso_in,
  output reg         l2_wr_out,
  output reg  [31:0] l2_addr_out,
  output reg  [7:0]  l2_data_out,
  output reg         pack16_out,
  output reg         jump_out,
  output reg  [31:0] jump_addr_out,
  output reg         busy_out,
  output reg         reserved_mode_out,
  output wire [2:0]  boot_mode_out
);
  localparam S_IDLE  = 3'h0;
  localparam S_SETUP = 3'h1;
  localparam S_FLASH = 3'h2;
  localparam S_CMD   = 3'h3;
  localparam S_RECV  = 3'h4;
  localparam S_DRAIN = 3'h5;
  localparam S_DONE  = 3'h6;
  localparam S_HALT  = 3'h7;

  // pin synchronisers for the strap and miso
  reg  [2:0] strap_m_q, strap_s_q;
  reg        miso_m_q, miso_s_q;
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      strap_m_q <= 3'h0;
      strap_s_q <= 3'h0;
      miso_m_q  <= 1'b0;
      miso_s_q  <= 1'b0;
    end else begin
      strap_m_q <= boot_select_strap_in;
      strap_s_q <= strap_m_q;
      miso_m_q  <= spi_miso_in;
      miso_s_q  <= miso_m_q;
    end
  end

  reg  [2:0]  state_q;
  reg  [2:0]  mode_q;
  reg  [1:0]  start_q;      // delay so the strap synchroniser fills after release
  reg         pend_q;       // boot requested
  reg         bypass_q;
  reg  [4:0]  tcnt_q;
  reg  [1:0]  phase_q;      // flash: setup/access/hold
  reg  [2:0]  hdr_q;
  reg  [31:0] count_q;
  reg  [31:0] src_q;
  reg  [31:0] dst_q;
  reg  [4:0]  bit_q;
  reg  [23:0] sh_q;
  reg  [7:0]  rx_q;
  reg  [3:0]  div_q;
  reg  [7:0]  byte_d;
  reg         byte_v;
  wire        fifo_rdy, fifo_v;
  wire [7:0]  fifo_dat;
  wire        sck_tick = (div_q == `RBL_SCK_HALF - 4'h1);
  wire        is_spi   = (mode_q == `RBL_MODE_SPI8) || (mode_q == `RBL_MODE_SPI16);
  wire        in_hdr   = (hdr_q != 3'h0);
  wire        sink     = (state_q == S_FLASH) || (state_q == S_RECV) || (state_q == S_DRAIN);
  wire        pop      = fifo_v && sink;
  assign boot_mode_out = mode_q;

  rbl_fifo #(.WIDTH(8), .DEPTH(`RBL_FIFO_DEPTH), .AW(3)) u_fifo (
    .clk_in       (clk_in),
    .rst_in       (rst_in),
    .clr_in       (state_q == S_IDLE),
    .wr_data_in   (byte_d),
    .wr_valid_in  (byte_v),
    .wr_ready_out (fifo_rdy),
    .rd_data_out  (fifo_dat),
    .rd_valid_out (fifo_v),
    .rd_ready_in  (pop)
  );

  // byte produced by either source this cycle
  always @* begin
    byte_d = 8'h00;
    byte_v = 1'b0;
    if (state_q == S_FLASH && phase_q == 2'h1 && tcnt_q == 5'h00) begin
      byte_d = flash_data_in;
      byte_v = 1'b1;
    end else if (state_q == S_RECV && spi_sck_out && sck_tick && bit_q == 5'h07) begin
      byte_d = {rx_q[6:0], miso_s_q};
      byte_v = 1'b1;
    end
  end

  // main sequencer
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= S_IDLE; mode_q <= 3'h0; start_q <= 2'h0; pend_q <= 1'b1;
      bypass_q <= 1'b0; tcnt_q <= 5'h00; phase_q <= 2'h0; hdr_q <= 3'h0;
      count_q <= 32'h0; src_q <= 32'h0; dst_q <= 32'h0; bit_q <= 5'h00;
      sh_q <= 24'h0; rx_q <= 8'h00; div_q <= 4'h0;
      flash_bank0_sel_out <= 1'b0; flash_rd_out <= 1'b0; flash_addr_out <= 32'h0;
      spi_boot_device_select_out <= 1'b0; spi_sck_out <= 1'b0; spi_mosi_out <= 1'b0;
      l2_wr_out <= 1'b0; l2_addr_out <= 32'h0; l2_data_out <= 8'h00;
      pack16_out <= 1'b0; jump_out <= 1'b0; jump_addr_out <= 32'h0;
      busy_out <= 1'b1; reserved_mode_out <= 1'b0;
    end else begin
      jump_out  <= 1'b0;
      l2_wr_out <= 1'b0;
      div_q     <= sck_tick ? 4'h0 : div_q + 4'h1;
      // software reset restarts sequencing and recaptures the strap
      if (sw_reset_in) begin
        state_q <= S_IDLE; start_q <= 2'h0; pend_q <= 1'b1;
        bypass_q <= sw_bypass_in;
        busy_out <= 1'b1;
        flash_bank0_sel_out <= 1'b0; flash_rd_out <= 1'b0;
        spi_boot_device_select_out <= 1'b0; spi_sck_out <= 1'b0;
        reserved_mode_out <= 1'b0; pack16_out <= 1'b0; // mode flags follow the new capture
      end else begin
        // payload write into l2, rising addresses
        if (pop) begin
          if (in_hdr) begin
            count_q <= {fifo_dat, count_q[31:8]};
            hdr_q   <= hdr_q - 3'h1;
          end else if (count_q != 32'h0) begin
            l2_wr_out   <= 1'b1;
            l2_addr_out <= dst_q;
            l2_data_out <= fifo_dat;
            dst_q       <= dst_q + 32'h1;
            count_q     <= count_q - 32'h1;
          end
        end
        case (state_q)
          S_IDLE: begin
            if (start_q != 2'h3) begin
              start_q <= start_q + 2'h1;
            end else if (pend_q) begin
              pend_q <= 1'b0;
              mode_q <= strap_s_q;
              hdr_q  <= `RBL_HDR_BYTES;
              count_q <= 32'h0; src_q <= 32'h0; dst_q <= `RBL_L2_START;
              if (bypass_q) begin
                state_q <= S_DONE;
              end else begin
                case (strap_s_q)
                  `RBL_MODE_EXT: begin
                    pack16_out <= 1'b1;
                    jump_out <= 1'b1;
                    jump_addr_out <= `RBL_EXT_START;
                    busy_out <= 1'b0;
                    state_q <= S_HALT;
                  end
                  `RBL_MODE_FLASH8: begin
                    state_q <= S_SETUP;
                  end
                  `RBL_MODE_SPI8: begin
                    sh_q <= {`RBL_SPI_READ_CMD, `RBL_SPI_ADDR};
                    bit_q <= 5'h0f;
                    spi_boot_device_select_out <= 1'b1;
                    state_q <= S_CMD;
                  end
                  `RBL_MODE_SPI16: begin
                    sh_q <= {`RBL_SPI_READ_CMD, `RBL_SPI_ADDR};
                    bit_q <= 5'h17;
                    spi_boot_device_select_out <= 1'b1;
                    state_q <= S_CMD;
                  end
                  default: begin
                    reserved_mode_out <= 1'b1;
                    busy_out <= 1'b0;
                    state_q <= S_HALT;
                  end
                endcase
              end
            end
          end
          S_SETUP: begin
            flash_bank0_sel_out <= 1'b1;
            flash_addr_out <= src_q;
            phase_q <= 2'h0;
            tcnt_q  <= `RBL_FL_SETUP - 5'h1;
            state_q <= S_FLASH;
          end
          S_FLASH: begin
            if (tcnt_q != 5'h00) begin
              tcnt_q <= tcnt_q - 5'h1;
            end else if (phase_q == 2'h0) begin
              flash_rd_out <= 1'b1;
              phase_q <= 2'h1;
              tcnt_q  <= `RBL_FL_ACCESS - 5'h1;
            end else if (phase_q == 2'h1) begin
              if (fifo_rdy) begin
                flash_rd_out <= 1'b0;
                phase_q <= 2'h2;
                tcnt_q  <= `RBL_FL_HOLD - 5'h1;
                src_q   <= src_q + 32'h1;
              end
            end else begin
              if (!in_hdr && count_q == 32'h0 && !fifo_v) begin
                flash_bank0_sel_out <= 1'b0;
                state_q <= S_DONE;
              end else if ((hdr_q > 3'h1) || (count_q > 32'h1)) begin
                state_q <= S_SETUP;
              end else if (hdr_q == 3'h1 || count_q == 32'h1) begin
                state_q <= S_SETUP;
              end else begin
                state_q <= S_DRAIN;
              end
            end
          end
          S_CMD: begin
            if (sck_tick) begin
              spi_sck_out <= ~spi_sck_out;
              if (!spi_sck_out) begin
                spi_mosi_out <= sh_q[23];
                sh_q <= {sh_q[22:0], 1'b0};
              end else if (bit_q == 5'h00) begin
                state_q <= S_RECV;
              end else begin
                bit_q <= bit_q - 5'h1;
              end
            end
          end
          S_RECV: begin
            if (sck_tick && (fifo_rdy || !spi_sck_out)) begin
              spi_sck_out <= ~spi_sck_out;
              if (spi_sck_out) begin
                rx_q  <= {rx_q[6:0], miso_s_q};
                bit_q <= (bit_q == 5'h07) ? 5'h00 : bit_q + 5'h1;
                if (bit_q == 5'h07 && !in_hdr && count_q <= 32'h1 && !(hdr_q == 3'h1)) begin
                  state_q <= S_DRAIN;
                end
              end
            end
            if (!in_hdr && count_q == 32'h0 && !fifo_v && bit_q == 5'h00 && !spi_sck_out) begin
              state_q <= S_DONE;
            end
          end
          S_DRAIN: begin
            spi_sck_out <= 1'b0;
            if (!fifo_v && !in_hdr && count_q == 32'h0) begin
              state_q <= S_DONE;
            end else if (!fifo_v && (in_hdr || count_q != 32'h0)) begin
              state_q <= is_spi ? S_RECV : S_SETUP;
            end
          end
          S_DONE: begin
            spi_boot_device_select_out <= 1'b0;
            flash_bank0_sel_out <= 1'b0;
            jump_out <= 1'b1;
            jump_addr_out <= `RBL_L2_START;
            busy_out <= 1'b0;
            state_q  <= S_HALT;
          end
          S_HALT: begin
            state_q <= S_HALT;
          end
          default: begin
            state_q <= S_IDLE;
          end
        endcase
      end
    end
  end
endmodule // rbl_boot

//--- rbl_boot_chk.sv
// assertion checker for the reset boot loader
`timescale 1ns/1ps
module rbl_boot_chk (
  input wire        clk_in,
  input wire        rst_in,
  input wire        sw_reset_in,
  input wire        flash_bank0_sel_out,
  input wire        flash_rd_out,
  input wire        spi_boot_device_select_out,
  input wire        spi_sck_out,
  input wire        l2_wr_out,
  input wire [31:0] l2_addr_out,
  input wire        pack16_out,
  input wire        jump_out,
  input wire [31:0] jump_addr_out,
  input wire        busy_out,
  input wire        reserved_mode_out,
  input wire [2:0]  boot_mode_out
);
  reg [4:0]  rd_len_q;
  reg [31:0] last_q;
  reg        seen_q;
  // strobe length counter and last l2 address written
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_len_q <= 5'h00;
      last_q   <= 32'h00000000;
      seen_q   <= 1'b0;
    end else begin
      rd_len_q <= flash_rd_out ? rd_len_q + 5'h01 : 5'h00;
      if (l2_wr_out) last_q <= l2_addr_out;
      seen_q <= sw_reset_in ? 1'b0 : (seen_q | l2_wr_out);
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // read strobe end and the hold that follows it
  sequence s_rd_end; $fell(flash_rd_out); endsequence
  sequence s_hold; !flash_rd_out [*3]; endsequence
  property p_rd_len; s_rd_end |-> rd_len_q == 5'h0f; endproperty
  property p_rd_hold; s_rd_end |-> s_hold; endproperty
  property p_rd_bank; flash_rd_out |-> flash_bank0_sel_out; endproperty
  property p_ext_addr; jump_out && pack16_out |-> jump_addr_out == 32'h02000000; endproperty
  property p_jump_pulse; jump_out |=> (!jump_out && !busy_out) [*2]; endproperty
  property p_l2_first; l2_wr_out && !seen_q |-> l2_addr_out == 32'h00000000; endproperty
  property p_l2_inc; l2_wr_out && seen_q |-> l2_addr_out == last_q + 32'h00000001; endproperty
  property p_resv;
    reserved_mode_out |-> !busy_out && !l2_wr_out && !flash_rd_out && !spi_boot_device_select_out;
  endproperty
  property p_sck_idle; !spi_boot_device_select_out |-> !spi_sck_out; endproperty
  property p_sel_mode; $rose(spi_boot_device_select_out) |-> boot_mode_out[2:1] == 2'h1; endproperty
  a_rd_len: assert property (p_rd_len) else $error("flash read strobe length wrong");
  a_rd_hold: assert property (p_rd_hold) else $error("flash hold too short");
  a_rd_bank: assert property (p_rd_bank) else $error("read without bank select");
  a_ext_addr: assert property (p_ext_addr) else $error("external start address wrong");
  a_jump_pulse: assert property (p_jump_pulse) else $error("jump not a single pulse");
  a_l2_first: assert property (p_l2_first) else $error("first l2 write not at start");
  a_l2_inc: assert property (p_l2_inc) else $error("l2 address not incrementing");
  a_resv: assert property (p_resv) else $error("activity in reserved mode");
  a_sck_idle: assert property (p_sck_idle) else $error("serial clock runs unselected");
  a_sel_mode: assert property (p_sel_mode) else $error("eeprom selected in non spi mode");
endmodule // rbl_boot_chk

bind rbl_boot rbl_boot_chk i_rbl_boot_chk (.*);

//--- rbl_mem_model.sv
// parallel flash and serial eeprom model holding the boot image
`timescale 1ns/1ps
module rbl_mem_model (
  input  wire        clk_in,
  input  wire        flash_rd_in,
  input  wire [31:0] flash_addr_in,
  output reg  [7:0]  flash_data_out,
  input  wire        sel_in,
  input  wire        sck_in,
  input  wire        mosi_in,
  input  wire        addr16_in,
  output reg         miso_out
);
  reg [7:0]  img [0:31];
  reg [31:0] cmd_q;
  integer    bit_q;
  wire [4:0] nbits = addr16_in ? 5'h18 : 5'h10;
  initial begin
    flash_data_out = 8'h00;
    miso_out = 1'b0;
    bit_q = 0;
  end
  // flash drives data only inside the read strobe, scrambled otherwise
  always @(posedge clk_in) begin
    if (flash_rd_in) flash_data_out <= img[flash_addr_in[4:0]];
    else flash_data_out <= ~flash_data_out;
  end
  // eeprom frame start and release
  always @(posedge sel_in) begin
    bit_q = 0;
    cmd_q = 32'h00000000;
  end
  always @(negedge sel_in) miso_out <= ~miso_out;
  // command and address bits taken on the falling clock
  always @(negedge sck_in) if (sel_in && bit_q <= nbits) cmd_q <= {cmd_q[30:0], mosi_in};
  // data shifted out msb first after command and address
  always @(posedge sck_in) begin
    if (bit_q >= nbits) miso_out <= img[(bit_q - nbits) / 8][7 - (bit_q - nbits) % 8];
    bit_q = bit_q + 1;
  end
endmodule // rbl_mem_model

//--- rbl_tb.sv
// testbench for the reset boot loader against the memory model
`timescale 1ns/1ps
`include "rbl_map.vh"
module testbench;
  reg         clk_in, rst_in, sw_reset_in, sw_bypass_in, addr16;
  reg  [2:0]  boot_select_strap_in;
  wire        flash_bank0_sel_out, flash_rd_out, spi_boot_device_select_out, spi_sck_out, spi_mosi_out;
  wire        spi_miso_in, l2_wr_out, pack16_out, jump_out, busy_out, reserved_mode_out;
  wire [31:0] flash_addr_out, l2_addr_out, jump_addr_out;
  wire [7:0]  flash_data_in, l2_data_out;
  wire [2:0]  boot_mode_out;
  reg  [7:0]  got [0:31];
  integer     mismatches, comparisons, nwr, cyc, k;
  rbl_boot i_rbl_boot (.*);
  rbl_mem_model i_rbl_mem_model (.clk_in(clk_in), .flash_rd_in(flash_rd_out), .flash_addr_in(flash_addr_out),
    .flash_data_out(flash_data_in), .sel_in(spi_boot_device_select_out), .sck_in(spi_sck_out),
    .mosi_in(spi_mosi_out), .addr16_in(addr16), .miso_out(spi_miso_in));
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  // l2 write collector and hang guard
  always @(posedge clk_in) begin
    if (l2_wr_out) got[l2_addr_out[4:0]] = l2_data_out;
    if (l2_wr_out) nwr = nwr + 1;
    cyc = cyc + 1;
    if (cyc == 40000) begin
      mismatches = mismatches + 1;
      finish_test;
    end
  end
  task chk(input string name, input [31:0] seen, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("ERROR %0s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  // image: little-endian count header, then payload base+i
  task set_img(input [7:0] cnt, input [7:0] base);
    begin
      for (k = 0; k < 32; k = k + 1) i_rbl_mem_model.img[k] = (k < 4) ? 8'h00 : base + k[7:0] - 8'h04;
      i_rbl_mem_model.img[0] = cnt;
    end
  endtask
  // one boot from power-on or software reset, waits for jump or halt
  task boot(input [2:0] s, input sw, input byp);
    begin
      repeat (3) @(negedge clk_in); // let a previous jump pulse and idle time pass
      boot_select_strap_in = s;
      sw_bypass_in = byp;
      nwr = 0;
      for (k = 0; k < 32; k = k + 1) got[k] = 8'hxx;
      if (sw) sw_reset_in = 1'b1;
      else rst_in = 1'b1;
      @(negedge clk_in);
      sw_reset_in = 1'b0;
      rst_in = 1'b0;
      for (k = 0; k < 5000 && jump_out !== 1'b1 && reserved_mode_out !== 1'b1; k = k + 1) @(negedge clk_in);
    end
  endtask
  task chk_load(input [7:0] cnt, input [7:0] base);
    begin
      chk("jump", jump_out, 32'h1);
      chk("jump_addr", jump_addr_out, `RBL_L2_START);
      chk("writes", nwr, cnt);
      for (k = 0; k < cnt; k = k + 1) chk("l2_data", got[k], base + k[7:0]);
    end
  endtask
  task t_ext;
    begin
      boot(3'h0, 1'b0, 1'b0);
      chk("ext_addr", jump_addr_out, 32'h02000000);
      chk("pack16", pack16_out, 32'h1);
      chk("ext_mode", boot_mode_out, 32'h0);
      chk("ext_writes", nwr, 32'h0);
    end
  endtask
  task t_flash;
    begin
      set_img(8'h05, 8'h50);
      boot(3'h1, 1'b0, 1'b0);
      chk("flash_mode", boot_mode_out, 32'h1);
      chk_load(8'h05, 8'h50);
    end
  endtask
  // spi boot entered by software reset so the strap is recaptured
  task t_spi(input a16, input [7:0] cnt, input [7:0] base);
    begin
      addr16 = a16;
      set_img(cnt, base);
      boot({2'h1, a16}, 1'b1, 1'b0);
      chk("spi_mode", boot_mode_out, {2'h1, a16});
      chk("spi_cmd", i_rbl_mem_model.cmd_q, a16 ? 32'h030000 : 32'h0300);
      chk("pack16_spi", pack16_out, 32'h0);
      chk_load(cnt, base);
    end
  endtask
  task t_resv;
    integer s;
    begin
      for (s = 4; s < 8; s = s + 1) begin
        boot(s[2:0], 1'b0, 1'b0);
        repeat (20) @(negedge clk_in);
        chk("reserved", reserved_mode_out, 32'h1);
        chk("busy", busy_out, 32'h0);
        chk("resv_writes", nwr, 32'h0);
      end
    end
  endtask
  task t_bypass;
    begin
      boot(3'h2, 1'b1, 1'b1);
      chk("bypass_jump", jump_out, 32'h1);
      chk("bypass_addr", jump_addr_out, `RBL_L2_START);
      chk("bypass_writes", nwr, 32'h0);
    end
  endtask
  task finish_test;
    begin
      if (mismatches == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  initial begin
    mismatches = 0;
    comparisons = 0;
    cyc = 0;
    nwr = 0;
    addr16 = 1'b0;
    rst_in = 1'b1;
    sw_reset_in = 1'b0;
    sw_bypass_in = 1'b0;
    boot_select_strap_in = 3'h0;
    repeat (10) @(negedge clk_in);
    rst_in = 1'b0;
    t_ext;
    t_flash;
    t_spi(1'b0, 8'h03, 8'h80);
    t_spi(1'b1, 8'h00, 8'h90);
    t_spi(1'b1, 8'h02, 8'hc0);
    t_resv;
    t_bypass;
    finish_test;
  end
endmodule // testbench
